//--- ecs_pkg.sv
`default_nettype none
package ecs_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ECS_ADDR_CSR = 8'h11;
	localparam logic [7:0] ECS_CSR_RESET = 8'h00;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int ECS_B_SSE_ACK = 7;
	localparam int ECS_B_OUT_ACK = 6;
	localparam int ECS_B_STALL_REQ = 5;
	localparam int ECS_B_SETUP_END = 4;
	localparam int ECS_B_DATA_END = 3;
	localparam int ECS_B_STALL_SENT = 2;
	localparam int ECS_B_IN_RDY = 1;
	localparam int ECS_B_OUT_RDY = 0;

	// events from the serial interface engine, each a one-cycle pulse
	typedef struct packed {
		logic out_rx;       // setup or out packet landed in fifo
		logic in_tx;        // in packet sent and acknowledged
		logic ctrl_end;     // control transaction ended
		logic stall_tx;     // stall handshake put on the wire
		logic proto_err;    // protocol error, hardware stall
		logic data_end_clr; // engine consumed the data-end mark
	} ecs_sie_ev_t;

	// levels towards the serial interface engine
	typedef struct packed {
		logic stall_req;
		logic in_ready;
		logic data_end;
		logic out_ready;
	} ecs_sie_ctl_t;
endpackage : ecs_pkg
`default_nettype wire

//--- ecs_ep0_csr.sv
`default_nettype none
module ecs_ep0_csr (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// endpoint select from the index register
	input wire logic [3:0] ep_index_i,
	// serial interface engine
	input wire ecs_pkg::ecs_sie_ev_t sie_ev_i,
	output ecs_pkg::ecs_sie_ctl_t sie_ctl_o,
	// endpoint zero interrupt pulse
	output logic ep0_irq_o
);
	import ecs_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic setup_end_flag_q, setup_end_flag_d;
	logic out_packet_ready_q, out_packet_ready_d;
	logic send_stall_request_q, send_stall_request_d;
	logic stall_sent_flag_q, stall_sent_flag_d;
	logic data_end_mark_q, data_end_mark_d;
	logic in_packet_ready_q, in_packet_ready_d;
	logic [7:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic csr_wr;
	logic csr_rd;
	logic [7:0] csr_view;
	logic sse_ack_wr;
	logic out_ack_wr;
	logic stall_set_wr;
	logic stall_sent_clr_wr;
	logic data_end_wr;
	logic in_rdy_wr;
	logic hw_setup_end;
	logic hw_stall;
	ecs_sie_ctl_t sie_ctl;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	// one decode for both strobes, so a read and a write always agree
	function automatic logic ecs_csr_hit(
		input logic [7:0] addr,
		input logic [3:0] index
	);
		return (addr == ECS_ADDR_CSR) && (index == 4'h0);
	endfunction : ecs_csr_hit

	// write-one action on a single data bit
	function automatic logic ecs_w1(
		input logic wr,
		input logic [7:0] data,
		input int pos
	);
		return wr && data[pos];
	endfunction : ecs_w1

	// index must be zero to reach the register; software's job to set it
	assign csr_wr = wr_i && ecs_csr_hit(addr_i, ep_index_i);
	assign csr_rd = rd_i && ecs_csr_hit(addr_i, ep_index_i);

	// ---------------------------------------------------------------
	// read view
	// ---------------------------------------------------------------
	always_comb begin
		csr_view = ECS_CSR_RESET;
		csr_view[ECS_B_SSE_ACK] = 1'b0;
		csr_view[ECS_B_OUT_ACK] = 1'b0;
		csr_view[ECS_B_STALL_REQ] = send_stall_request_q;
		csr_view[ECS_B_SETUP_END] = setup_end_flag_q;
		csr_view[ECS_B_DATA_END] = data_end_mark_q;
		csr_view[ECS_B_STALL_SENT] = stall_sent_flag_q;
		csr_view[ECS_B_IN_RDY] = in_packet_ready_q;
		csr_view[ECS_B_OUT_RDY] = out_packet_ready_q;
	end

	// ---------------------------------------------------------------
	// software actions
	// ---------------------------------------------------------------
	always_comb begin
		sse_ack_wr = ecs_w1(csr_wr, wdata_i, ECS_B_SSE_ACK);
		out_ack_wr = ecs_w1(csr_wr, wdata_i, ECS_B_OUT_ACK);
		stall_set_wr = ecs_w1(csr_wr, wdata_i, ECS_B_STALL_REQ);
		data_end_wr = ecs_w1(csr_wr, wdata_i, ECS_B_DATA_END);
		in_rdy_wr = ecs_w1(csr_wr, wdata_i, ECS_B_IN_RDY);
		// clears on a zero, so firmware must write the bit high to keep it
		stall_sent_clr_wr = csr_wr && !wdata_i[ECS_B_STALL_SENT];
	end

	// ---------------------------------------------------------------
	// engine events
	// ---------------------------------------------------------------
	// data-end already written means the ending was expected, not early
	always_comb begin
		hw_setup_end = sie_ev_i.ctrl_end && !data_end_mark_q;
		hw_stall = sie_ev_i.stall_tx || sie_ev_i.proto_err;
	end

	// ---------------------------------------------------------------
	// setup-end flag
	// ---------------------------------------------------------------
	// engine set applied after the software clear, so the set wins
	always_comb begin
		setup_end_flag_d = setup_end_flag_q;
		if (sse_ack_wr) begin
			setup_end_flag_d = 1'b0;
		end
		if (hw_setup_end) begin
			setup_end_flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			setup_end_flag_q <= 1'b0;
		end else begin
			setup_end_flag_q <= setup_end_flag_d;
		end
	end

	// ---------------------------------------------------------------
	// out-ready flag
	// ---------------------------------------------------------------
	// read-only: only the ack bit clears it, never a direct write
	always_comb begin
		out_packet_ready_d = out_packet_ready_q;
		if (out_ack_wr) begin
			out_packet_ready_d = 1'b0;
		end
		if (sie_ev_i.out_rx) begin
			out_packet_ready_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			out_packet_ready_q <= 1'b0;
		end else begin
			out_packet_ready_q <= out_packet_ready_d;
		end
	end

	// ---------------------------------------------------------------
	// stall request
	// ---------------------------------------------------------------
	// engine clear last: a request landing with the stall is spent by it
	always_comb begin
		send_stall_request_d = send_stall_request_q;
		if (stall_set_wr) begin
			send_stall_request_d = 1'b1;
		end
		if (sie_ev_i.stall_tx) begin
			send_stall_request_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			send_stall_request_q <= 1'b0;
		end else begin
			send_stall_request_q <= send_stall_request_d;
		end
	end

	// ---------------------------------------------------------------
	// stall-sent flag
	// ---------------------------------------------------------------
	always_comb begin
		stall_sent_flag_d = stall_sent_flag_q;
		if (stall_sent_clr_wr) begin
			stall_sent_flag_d = 1'b0;
		end
		if (hw_stall) begin
			stall_sent_flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			stall_sent_flag_q <= 1'b0;
		end else begin
			stall_sent_flag_q <= stall_sent_flag_d;
		end
	end

	// ---------------------------------------------------------------
	// data-end mark
	// ---------------------------------------------------------------
	always_comb begin
		data_end_mark_d = data_end_mark_q;
		if (data_end_wr) begin
			data_end_mark_d = 1'b1;
		end
		if (sie_ev_i.data_end_clr) begin
			data_end_mark_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			data_end_mark_q <= 1'b0;
		end else begin
			data_end_mark_q <= data_end_mark_d;
		end
	end

	// ---------------------------------------------------------------
	// in-ready flag
	// ---------------------------------------------------------------
	always_comb begin
		in_packet_ready_d = in_packet_ready_q;
		if (in_rdy_wr) begin
			in_packet_ready_d = 1'b1;
		end
		if (sie_ev_i.in_tx) begin
			in_packet_ready_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			in_packet_ready_q <= 1'b0;
		end else begin
			in_packet_ready_q <= in_packet_ready_d;
		end
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	// zero outside the answer cycle, so a stale byte never looks valid
	always_comb begin
		rdata_d = 8'h00;
		if (csr_rd) begin
			rdata_d = csr_view;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ---------------------------------------------------------------
	// interrupt
	// ---------------------------------------------------------------
	// one pulse however many events share a cycle; firmware reads the flags
	always_comb begin
		irq_d = 1'b0;
		if (sie_ev_i.out_rx) begin
			irq_d = 1'b1;
		end
		if (sie_ev_i.in_tx) begin
			irq_d = 1'b1;
		end
		if (hw_setup_end) begin
			irq_d = 1'b1;
		end
		if (hw_stall) begin
			irq_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	always_comb begin
		sie_ctl = '0;
		sie_ctl.stall_req = send_stall_request_q;
		sie_ctl.in_ready = in_packet_ready_q;
		sie_ctl.data_end = data_end_mark_q;
		sie_ctl.out_ready = out_packet_ready_q;
	end

	assign rdata_o = rdata_q;
	assign ep0_irq_o = irq_q;
	assign sie_ctl_o = sie_ctl;
endmodule : ecs_ep0_csr
`default_nettype wire

//--- ecs_ep0_csr_asserts.sv
`default_nettype none
module ecs_ep0_csr_asserts (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// endpoint select, engine and interrupt
	input wire logic [3:0] ep_index_i,
	input wire ecs_pkg::ecs_sie_ev_t sie_ev_i,
	input wire ecs_pkg::ecs_sie_ctl_t sie_ctl_o,
	input wire logic ep0_irq_o
);
	import ecs_pkg::*;
	wire s = addr_i == ECS_ADDR_CSR && ep_index_i == 4'h0;
	wire w = wr_i && s;
	wire [5:0] e = sie_ev_i;
	wire [3:0] c = sie_ctl_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	AST_SE_ACK: assert property (w && wdata_i[7] && !e[3] ##1 !e[3] ##1 rd_i && s
		|=> !rdata_o[4]) else $error("setup end kept");
	AST_OUT_ACK: assert property (w && wdata_i[6] && !e[5] |=> !c[0]) else $error("out kept");
	AST_ACK_RD: assert property (rd_i |=> rdata_o[7:6] == 2'b00) else $error("ack read");
	AST_OUT_SET: assert property (e[5] |=> c[0] && ep0_irq_o) else $error("out set");
	AST_STL_REQ: assert property (w && wdata_i[5] && !e[2] |=> c[3]) else $error("stall");
	AST_STL_CLR: assert property (e[2] && !w |=> !c[3]) else $error("stall kept");
	AST_STL_IRQ: assert property (e[2] || e[1] |=> ep0_irq_o) else $error("stall irq");
	AST_SE_SET: assert property (e[3] && !c[1] |=> ep0_irq_o) else $error("end irq");
endmodule : ecs_ep0_csr_asserts
bind ecs_ep0_csr ecs_ep0_csr_asserts u_ecs_ep0_csr_asserts (.clk_i, .sys_rst_i, .wr_i, .rd_i,
	.ep0_irq_o, .addr_i, .wdata_i, .rdata_o, .ep_index_i, .sie_ev_i, .sie_ctl_o);
`default_nettype wire

//--- ecs_sie_model.sv
`default_nettype none
module ecs_sie_model (
	input wire logic clk_i,
	input wire logic [5:0] kick_i,
	input wire logic [3:0] dly_i,
	input wire ecs_pkg::ecs_sie_ctl_t ctl_i,
	output ecs_pkg::ecs_sie_ev_t ev_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] n = 4'h0;
	initial ev_o = '0;
	// stall goes out dly_i + 1 cycles after the request, so slow hosts are covered too
	always @(posedge clk_i) begin
		ev_o <= kick_i;
		n <= ctl_i.stall_req && !ev_o.stall_tx ? n + 4'h1 : 4'h0;
		if (ctl_i.stall_req && !ev_o.stall_tx && n == dly_i) ev_o.stall_tx <= 1'b1;
	end
endmodule : ecs_sie_model
`default_nettype wire

//--- ecs_ep0_csr_test.sv
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module ecs_ep0_csr_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ecs_pkg::*;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, ep0_irq_o;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
	logic [3:0] ep_index_i = 4'h0, dly_i = 4'h6;
	logic [5:0] kick_i = 6'h00;
	ecs_sie_ev_t sie_ev_i;
	ecs_sie_ctl_t sie_ctl_o;
	int errors = 0, checks = 0, irqs = 0;
	// op: 0 write, 1 read and compare, 2 engine event, 3 set index and stall delay
	logic [17:0] t [$] = {
		18'h11100, 18'h20020, 18'h11101,
		18'h01140, 18'h11100,
		18'h20008, 18'h11110, 18'h01180, 18'h11100,
		18'h0110A, 18'h20008, 18'h1110A, 18'h20010, 18'h11108, 18'h20001, 18'h11100,
		18'h01120, 18'h11120, 18'h30006, 18'h11104,
		18'h01100, 18'h11100, 18'h20002, 18'h11104, 18'h01100,
		18'h30010, 18'h0110A, 18'h30000, 18'h11100, 18'h0120A, 18'h11100, 18'h11200,
		18'h01120, 18'h30000, 18'h11104
	};
	always #4 clk_i = ~clk_i;
	// counts high cycles, so a stuck interrupt shows as too many
	always @(posedge clk_i) if (ep0_irq_o === 1'b1) irqs <= irqs + 1;
	ecs_ep0_csr u_ecs_ep0_csr (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.ep_index_i, .sie_ev_i, .sie_ctl_o, .ep0_irq_o);
	ecs_sie_model u_ecs_sie_model (.clk_i, .kick_i, .dly_i, .ctl_i(sie_ctl_o), .ev_o(sie_ev_i));
	task end_of_test;
		if (errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	// the table needs a few hundred cycles at most
	initial begin
		repeat (2000) @(posedge clk_i);
		errors++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		foreach (t[i]) begin
			@(posedge clk_i);
			{addr_i, wdata_i} <= t[i][15:0];
			wr_i <= t[i][17:16] == 2'd0;
			rd_i <= t[i][17:16] == 2'd1;
			kick_i <= t[i][17:16] == 2'd2 ? t[i][5:0] : 6'h00;
			if (t[i][17:16] == 2'd3) {ep_index_i, dly_i} <= t[i][7:0];
			@(posedge clk_i);
			{wr_i, rd_i, kick_i} <= '0;
			repeat (t[i][17] ? 8 : 0) @(posedge clk_i);
			#1;
			if (t[i][17:16] == 2'd1) begin
				`CHK(rdata_o, t[i][7:0])
				`CHK(sie_ctl_o, ({t[i][5], t[i][1], t[i][3], t[i][0]}))
			end
		end
		`CHK(irqs, 6)
		end_of_test();
	end
endmodule : ecs_ep0_csr_test
`default_nettype wire
